// file: rtl/discharge_protection_pkg.sv
// Shared constants, register map and types for the discharge protection block.
package discharge_protection_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock rate and time figures.
  localparam int CLK_FREQ_MHZ = 20;
  localparam int OC_BASE_TIMEOUT_US = 160000;
  localparam int OC_BASE_TIMEOUT_CYCLES = OC_BASE_TIMEOUT_US * CLK_FREQ_MHZ;
  localparam int DELAY_DIVIDE_FACTOR = 64;
  localparam int TIMER_WIDTH = 26;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map of the serial register port.
  localparam logic [7:0] FET_CONTROL_ADDR = 8'h04;
  localparam logic [7:0] DISCHARGE_CONFIG_ADDR = 8'h05;
  localparam logic [7:0] TIME_SCALE_ADDR = 8'h06;
  localparam logic [7:0] PROTECTION_STATUS_ADDR = 8'h08;

  // Bit positions inside the shared registers.
  localparam int FET_DISCHARGE_BIT = 0;
  localparam int TIME_SCALE_DIVIDE_BIT = 2;
  localparam int STATUS_OC_BIT = 0;
  localparam int STATUS_SC_BIT = 1;

  // Reset values.
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Field layout of the discharge configuration register, bit 7 down to bit 0.
  typedef struct packed {
    logic discharge_oc_auto_off_disable;
    logic [1:0] discharge_oc_threshold_sel;
    logic short_circuit_auto_off_disable;
    logic [1:0] short_circuit_threshold_sel;
    logic [1:0] discharge_oc_delay_sel;
  } discharge_config_type;

  // Sticky protection flags.
  typedef struct packed {
    logic short_circuit_flag;
    logic discharge_oc_flag;
  } status_type;

  // Discharge overcurrent qualification states.
  typedef enum logic [1:0] {
    OC_IDLE = 2'b00,
    OC_TIMING = 2'b01,
    OC_TRIPPED = 2'b10
  } oc_state_type;

  // Timeout in cycles: base doubles per code step, optionally divided.
  function automatic logic [TIMER_WIDTH-1:0] oc_timeout_cycles(
    input logic [TIMER_WIDTH-1:0] base_cycles,
    input logic [1:0] delay_sel,
    input logic divide
  );
    logic [TIMER_WIDTH-1:0] scaled;
    scaled = base_cycles << delay_sel;
    if (divide) begin
      scaled = scaled / TIMER_WIDTH'(DELAY_DIVIDE_FACTOR);
    end
    return scaled;
  endfunction : oc_timeout_cycles

endpackage : discharge_protection_pkg

// file: rtl/level_sync.sv
// Two flip-flop synchroniser for asynchronous comparator levels.
`timescale 1ns/100ps
`default_nettype none

module level_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync_out;

  // The pin enters the first stage untouched; reset only clears the second stage,
  // so no gate ever looks at the raw asynchronous level.
  always_comb begin
    next_meta = async_in;
    next_sync_out = srst ? '0 : meta;
  end

  // Both stages are plain registers.
  always_ff @(posedge clk) begin
    meta <= next_meta;
    sync_out <= next_sync_out;
  end

endmodule : level_sync

`default_nettype wire

// file: rtl/persistence_timer.sv
// Counter that flags when an input has held continuously for a given number of cycles.
`timescale 1ns/100ps
`default_nettype none

module persistence_timer #(
  parameter int WIDTH = 26
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic active,
  input wire logic [WIDTH-1:0] limit,
  output logic expired
);

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic next_expired;

  // Count while active, restart from zero the moment the condition drops.
  // The limit is compared live, so a delay change during timing takes effect at once.
  always_comb begin
    next_count = count;
    next_expired = 1'b0;
    if (srst || !active) begin
      next_count = '0;
    end else begin
      if (count != '1) begin
        next_count = count + WIDTH'(1);
      end
      next_expired = (next_count >= limit);
    end
  end

  always_ff @(posedge clk) begin
    count <= next_count;
    expired <= next_expired;
  end

endmodule : persistence_timer

`default_nettype wire

// file: rtl/discharge_protection_config.sv
// Discharge protection configuration register and automatic shutdown logic.
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module discharge_protection_config #(
  parameter int OC_BASE_TIMEOUT = discharge_protection_pkg::OC_BASE_TIMEOUT_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic reg_write_strobe,
  input wire logic reg_read_strobe,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_write_data,
  output logic [7:0] reg_read_data,
  output logic reg_read_valid,
  input wire logic discharge_oc_detect,
  input wire logic short_circuit_detect,
  output logic [1:0] discharge_oc_threshold_voltage,
  output logic [1:0] short_circuit_threshold_voltage,
  output logic discharge_fet_enable,
  output logic discharge_delay_divide,
  output logic discharge_oc_flag,
  output logic short_circuit_flag,
  output logic temp_sensor_supply_out
);

  import discharge_protection_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.

  discharge_config_type config_reg;
  discharge_config_type next_config_reg;
  status_type status;
  status_type next_status;
  oc_state_type oc_state;
  oc_state_type next_oc_state;

  logic next_discharge_fet_enable;
  logic next_discharge_delay_divide;
  logic next_temp_sensor_supply_out;
  logic [7:0] next_reg_read_data;
  logic next_reg_read_valid;

  logic [1:0] detect_sync;
  logic oc_level;
  logic sc_level;
  logic timer_active;
  logic timer_expired;
  logic [TIMER_WIDTH-1:0] timeout_limit;
  logic oc_event;
  logic oc_shutdown;
  logic sc_shutdown;

  logic write_fet;
  logic write_config;
  logic write_scale;
  logic write_status;

  ////////////////////////////////////////////////////////////////////////////////
  // Comparator inputs come from the analog side and are synchronised first.

  level_sync #(
    .WIDTH(2)
  ) u_detect_sync (
    .clk(clk),
    .srst(srst),
    .async_in({short_circuit_detect, discharge_oc_detect}),
    .sync_out(detect_sync)
  );

  assign oc_level = detect_sync[0];
  assign sc_level = detect_sync[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Register write decode.

  // One decode per register keeps the priority logic below readable.
  always_comb begin
    write_fet = reg_write_strobe && (reg_addr == FET_CONTROL_ADDR);
    write_config = reg_write_strobe && (reg_addr == DISCHARGE_CONFIG_ADDR);
    write_scale = reg_write_strobe && (reg_addr == TIME_SCALE_ADDR);
    write_status = reg_write_strobe && (reg_addr == PROTECTION_STATUS_ADDR);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration and time scale bits.

  // The configuration register is fully writable; the time scale register only holds
  // the divider bit here, its other bits belong to the charge side.
  always_comb begin
    next_config_reg = config_reg;
    next_discharge_delay_divide = discharge_delay_divide;
    if (srst) begin
      next_config_reg = discharge_config_type'(CONFIG_RESET);
      next_discharge_delay_divide = 1'b0;
    end else begin
      if (write_config) begin
        next_config_reg = discharge_config_type'(reg_write_data);
      end
      if (write_scale) begin
        next_discharge_delay_divide = reg_write_data[TIME_SCALE_DIVIDE_BIT];
      end
    end
  end

  always_ff @(posedge clk) begin
    config_reg <= next_config_reg;
    discharge_delay_divide <= next_discharge_delay_divide;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Threshold selects go straight to the analog comparators as two-bit codes.

  // The codes map to voltages in the comparator reference ladder, not in logic.
  always_ff @(posedge clk) begin
    if (srst) begin
      discharge_oc_threshold_voltage <= 2'h0;
      short_circuit_threshold_voltage <= 2'h0;
    end else begin
      discharge_oc_threshold_voltage <= next_config_reg.discharge_oc_threshold_sel;
      short_circuit_threshold_voltage <= next_config_reg.short_circuit_threshold_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Discharge overcurrent qualification.

  // Timeout doubles per code step and is divided by 64 with the divider on.
  always_comb begin
    timeout_limit = oc_timeout_cycles(TIMER_WIDTH'(OC_BASE_TIMEOUT),
                                      config_reg.discharge_oc_delay_sel,
                                      discharge_delay_divide);
  end

  // The timer only runs while the indication is present in the timing state.
  assign timer_active = (oc_state == OC_TIMING) && oc_level;

  persistence_timer #(
    .WIDTH(TIMER_WIDTH)
  ) u_oc_timer (
    .clk(clk),
    .srst(srst),
    .active(timer_active),
    .limit(timeout_limit),
    .expired(timer_expired)
  );

  // A trip stays latched while the indication persists, so the host cannot
  // re-enable the FET into a fault that is still present.
  always_comb begin
    next_oc_state = oc_state;
    oc_event = 1'b0;
    unique case (oc_state)
      OC_IDLE: begin
        if (oc_level) begin
          next_oc_state = OC_TIMING;
        end
      end
      OC_TIMING: begin
        if (!oc_level) begin
          next_oc_state = OC_IDLE;
        end else if (timer_expired) begin
          next_oc_state = OC_TRIPPED;
          oc_event = 1'b1;
        end
      end
      OC_TRIPPED: begin
        if (!oc_level) begin
          next_oc_state = OC_IDLE;
        end
      end
      default: begin
        next_oc_state = OC_IDLE;
      end
    endcase
    if (srst) begin
      next_oc_state = OC_IDLE;
      oc_event = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    oc_state <= next_oc_state;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Automatic shutdown requests.

  // Short circuits act on the synchronised level; their own delay is analog.
  always_comb begin
    oc_shutdown = (oc_event || (oc_state == OC_TRIPPED))
                  && !config_reg.discharge_oc_auto_off_disable;
    sc_shutdown = sc_level && !config_reg.short_circuit_auto_off_disable;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Discharge FET enable bit.

  // Hardware shutdown wins over a host write in the same cycle.
  always_comb begin
    next_discharge_fet_enable = discharge_fet_enable;
    if (srst) begin
      next_discharge_fet_enable = 1'b0;
    end else begin
      if (write_fet) begin
        next_discharge_fet_enable = reg_write_data[FET_DISCHARGE_BIT];
      end
      if (oc_shutdown || sc_shutdown) begin
        next_discharge_fet_enable = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    discharge_fet_enable <= next_discharge_fet_enable;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky status flags and temperature-sensor supply.

  // Flags are cleared by writing 1; a new event in the same cycle keeps the flag set.
  always_comb begin
    next_status = status;
    if (srst) begin
      next_status = '0;
    end else begin
      if (write_status && reg_write_data[STATUS_OC_BIT]) begin
        next_status.discharge_oc_flag = 1'b0;
      end
      if (write_status && reg_write_data[STATUS_SC_BIT]) begin
        next_status.short_circuit_flag = 1'b0;
      end
      if (oc_event) begin
        next_status.discharge_oc_flag = 1'b1;
      end
      if (sc_level) begin
        next_status.short_circuit_flag = 1'b1;
      end
    end
    next_temp_sensor_supply_out = next_status.discharge_oc_flag
                                  || next_status.short_circuit_flag;
  end

  always_ff @(posedge clk) begin
    status <= next_status;
    discharge_oc_flag <= next_status.discharge_oc_flag;
    short_circuit_flag <= next_status.short_circuit_flag;
    temp_sensor_supply_out <= next_temp_sensor_supply_out;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register readback.

  // Unmapped addresses and bits owned by other blocks read as zero.
  always_comb begin
    next_reg_read_data = reg_read_data;
    next_reg_read_valid = 1'b0;
    if (srst) begin
      next_reg_read_data = READ_ZERO;
    end else if (reg_read_strobe) begin
      next_reg_read_valid = 1'b1;
      next_reg_read_data = READ_ZERO;
      unique case (reg_addr)
        FET_CONTROL_ADDR: begin
          next_reg_read_data[FET_DISCHARGE_BIT] = discharge_fet_enable;
        end
        DISCHARGE_CONFIG_ADDR: begin
          next_reg_read_data = 8'(config_reg);
        end
        TIME_SCALE_ADDR: begin
          next_reg_read_data[TIME_SCALE_DIVIDE_BIT] = discharge_delay_divide;
        end
        PROTECTION_STATUS_ADDR: begin
          next_reg_read_data[STATUS_OC_BIT] = status.discharge_oc_flag;
          next_reg_read_data[STATUS_SC_BIT] = status.short_circuit_flag;
        end
        default: begin
          next_reg_read_data = READ_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    reg_read_data <= next_reg_read_data;
    reg_read_valid <= next_reg_read_valid;
  end

endmodule : discharge_protection_config

`default_nettype wire

// file: verification/discharge_protection_props.sv
// Concurrent checks on the ports of the discharge protection block.
`timescale 1ns/100ps
`default_nettype none

module discharge_protection_props #(
  parameter int OC_BASE_TIMEOUT = discharge_protection_pkg::OC_BASE_TIMEOUT_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic reg_write_strobe,
  input wire logic reg_read_strobe,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_write_data,
  input wire logic [7:0] reg_read_data,
  input wire logic reg_read_valid,
  input wire logic discharge_oc_detect,
  input wire logic short_circuit_detect,
  input wire logic [1:0] discharge_oc_threshold_voltage,
  input wire logic [1:0] short_circuit_threshold_voltage,
  input wire logic discharge_fet_enable,
  input wire logic discharge_delay_divide,
  input wire logic discharge_oc_flag,
  input wire logic short_circuit_flag,
  input wire logic temp_sensor_supply_out
);
  import discharge_protection_pkg::*;
  // The shortest legal timeout, less the slack of the synchroniser.
  localparam int MIN_RUN = OC_BASE_TIMEOUT / DELAY_DIVIDE_FACTOR - 2;
  logic [7:0] cfg;
  logic [15:0] oc_run;

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////////////////////
  // Shadow of the config register and the run length of the raw overcurrent level.
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg <= 8'h00;
      oc_run <= 16'h0000;
    end else begin
      if (reg_write_strobe && reg_addr == DISCHARGE_CONFIG_ADDR) begin
        cfg <= reg_write_data;
      end
      oc_run <= !discharge_oc_detect ? 16'h0000 : (&oc_run ? oc_run : oc_run + 16'h0001);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_oc_thr_follow: assert property (
    reg_write_strobe && reg_addr == DISCHARGE_CONFIG_ADDR
    |=> discharge_oc_threshold_voltage == $past(reg_write_data[6:5]))
    else $error("oc threshold code wrong");
  a_sc_thr_follow: assert property (
    reg_write_strobe && reg_addr == DISCHARGE_CONFIG_ADDR
    |=> short_circuit_threshold_voltage == $past(reg_write_data[3:2]))
    else $error("sc threshold code wrong");
  a_cfg_read_back: assert property (
    reg_read_strobe && reg_addr == DISCHARGE_CONFIG_ADDR
    |=> reg_read_valid && reg_read_data == $past(cfg))
    else $error("config read back wrong");
  a_sc_fet_off: assert property (
    short_circuit_detect [*5] ##0 !cfg[4] |-> !discharge_fet_enable)
    else $error("fet on during short");
  a_sc_flag_set: assert property (
    short_circuit_detect [*5] |-> short_circuit_flag && temp_sensor_supply_out)
    else $error("short flag or supply missing");
  a_no_auto_off: assert property (
    cfg[7] && cfg[4] && discharge_fet_enable && !(reg_write_strobe && reg_addr == FET_CONTROL_ADDR)
    |=> discharge_fet_enable)
    else $error("fet dropped with auto off disabled");
  a_oc_min_run: assert property (
    $rose(discharge_oc_flag) |-> $past(oc_run, 3) >= MIN_RUN)
    else $error("oc flag before timeout");
  a_oc_fet_off: assert property (
    $rose(discharge_oc_flag) && !cfg[7] |-> ##[0:1] !discharge_fet_enable)
    else $error("fet left on after oc trip");
  a_oc_temp_on: assert property (
    $rose(discharge_oc_flag) |-> ##[0:1] temp_sensor_supply_out)
    else $error("supply off after oc trip");
endmodule : discharge_protection_props
`default_nettype wire

// file: verification/host_model.sv
// Host microcontroller model that drives the register port.
`timescale 1ns/100ps
`default_nettype none

module host_model (
  input wire logic clk,
  output var logic reg_write_strobe,
  output var logic reg_read_strobe,
  output var logic [7:0] reg_addr,
  output var logic [7:0] reg_write_data,
  input wire logic [7:0] reg_read_data,
  input wire logic reg_read_valid
);
  // Idle bus starts quiet.
  initial begin
    reg_write_strobe = 1'h0;
    reg_read_strobe = 1'h0;
    reg_addr = 8'h00;
    reg_write_data = 8'h00;
  end

  // Requests change at falling edges; a released bus shows the inverse so stale values never match.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_write_data = d;
    reg_write_strobe = 1'h1;
    @(negedge clk);
    reg_write_strobe = 1'h0;
    reg_addr = ~a;
    reg_write_data = ~d;
  endtask : wr

  // Bounded wait for the valid pulse; read data holds until the next read.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(negedge clk);
    reg_addr = a;
    reg_read_strobe = 1'h1;
    @(negedge clk);
    reg_read_strobe = 1'h0;
    reg_addr = ~a;
    n = 0;
    while (reg_read_valid !== 1'h1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    d = (reg_read_valid === 1'h1) ? reg_read_data : 8'hxx;
  endtask : rd
endmodule : host_model
`default_nettype wire

// file: verification/testbench.sv
// Self-checking testbench for the discharge protection block.
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import discharge_protection_pkg::*;
  // Short base timeout keeps the run brief; divided it gives 10 cycles.
  localparam int BASE = 640;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic reg_write_strobe, reg_read_strobe, reg_read_valid;
  logic [7:0] reg_addr, reg_write_data, reg_read_data, d;
  logic discharge_oc_detect = 1'h0;
  logic short_circuit_detect = 1'h0;
  logic [1:0] discharge_oc_threshold_voltage, short_circuit_threshold_voltage;
  logic discharge_fet_enable, discharge_delay_divide, discharge_oc_flag, short_circuit_flag;
  logic temp_sensor_supply_out;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #25 clk = ~clk;

  host_model host (
    .clk(clk),
    .reg_write_strobe(reg_write_strobe),
    .reg_read_strobe(reg_read_strobe),
    .reg_addr(reg_addr),
    .reg_write_data(reg_write_data),
    .reg_read_data(reg_read_data),
    .reg_read_valid(reg_read_valid)
  );

  discharge_protection_config #(
    .OC_BASE_TIMEOUT(BASE)
  ) uut (
    .clk(clk),
    .srst(srst),
    .reg_write_strobe(reg_write_strobe),
    .reg_read_strobe(reg_read_strobe),
    .reg_addr(reg_addr),
    .reg_write_data(reg_write_data),
    .reg_read_data(reg_read_data),
    .reg_read_valid(reg_read_valid),
    .discharge_oc_detect(discharge_oc_detect),
    .short_circuit_detect(short_circuit_detect),
    .discharge_oc_threshold_voltage(discharge_oc_threshold_voltage),
    .short_circuit_threshold_voltage(short_circuit_threshold_voltage),
    .discharge_fet_enable(discharge_fet_enable),
    .discharge_delay_divide(discharge_delay_divide),
    .discharge_oc_flag(discharge_oc_flag),
    .short_circuit_flag(short_circuit_flag),
    .temp_sensor_supply_out(temp_sensor_supply_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // A hang is cut short well past the expected run length.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic conclude;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // Hold overcurrent to just short of the timeout, then past it, then clear the flags.
  task automatic oc_trip(input int lim);
    discharge_oc_detect = 1'h1;
    cyc(lim - 3);
    chk("oc flag early", 8'h00, {7'h00, discharge_oc_flag});
    cyc(15);
    chk("oc flag", 8'h01, {7'h00, discharge_oc_flag});
    chk("temp supply", 8'h01, {7'h00, temp_sensor_supply_out});
    host.rd(PROTECTION_STATUS_ADDR, d);
    chk("oc status", 8'h01, d);
    discharge_oc_detect = 1'h0;
    cyc(4);
    host.wr(PROTECTION_STATUS_ADDR, 8'h03);
  endtask : oc_trip

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    cyc(6);
    srst = 1'h0;
    host.rd(DISCHARGE_CONFIG_ADDR, d);
    chk("config reset", CONFIG_RESET, d);
    for (int i = 0; i < 4; i++) begin
      host.wr(DISCHARGE_CONFIG_ADDR, {1'h1, 2'(i), 1'h1, ~2'(i), 2'h0});
      chk("oc threshold", 8'(i), {6'h00, discharge_oc_threshold_voltage});
      chk("sc threshold", {6'h00, ~2'(i)}, {6'h00, short_circuit_threshold_voltage});
    end
    host.rd(DISCHARGE_CONFIG_ADDR, d);
    chk("config read", 8'hF0, d);
    host.rd(8'h10, d);
    chk("unmapped read", READ_ZERO, d);
    host.wr(FET_CONTROL_ADDR, 8'h01);
    short_circuit_detect = 1'h1;
    cyc(6);
    chk("fet kept", 8'h01, {7'h00, discharge_fet_enable});
    chk("sc flag", 8'h01, {7'h00, short_circuit_flag});
    chk("temp supply", 8'h01, {7'h00, temp_sensor_supply_out});
    host.rd(PROTECTION_STATUS_ADDR, d);
    chk("status", 8'h02, d);
    short_circuit_detect = 1'h0;
    cyc(4);
    host.wr(PROTECTION_STATUS_ADDR, 8'h03);
    host.wr(DISCHARGE_CONFIG_ADDR, 8'h80);
    short_circuit_detect = 1'h1;
    cyc(6);
    chk("fet off", 8'h00, {7'h00, discharge_fet_enable});
    short_circuit_detect = 1'h0;
    cyc(4);
    host.wr(FET_CONTROL_ADDR, 8'h01);
    host.rd(FET_CONTROL_ADDR, d);
    chk("fet restored", 8'h01, d);
    host.wr(PROTECTION_STATUS_ADDR, 8'h03);
    for (int v = 0; v < 2; v++) begin
      for (int c = 0; c < 4; c++) begin
        host.wr(TIME_SCALE_ADDR, (v == 1) ? 8'h04 : 8'h00);
        host.wr(DISCHARGE_CONFIG_ADDR, 8'(c));
        host.wr(FET_CONTROL_ADDR, 8'h01);
        chk("divider", 8'(v), {7'h00, discharge_delay_divide});
        host.rd(TIME_SCALE_ADDR, d);
        chk("scale read", (v == 1) ? 8'h04 : 8'h00, d);
        oc_trip((BASE << c) / ((v == 1) ? DELAY_DIVIDE_FACTOR : 1));
        chk("fet tripped", 8'h00, {7'h00, discharge_fet_enable});
      end
    end
    host.wr(DISCHARGE_CONFIG_ADDR, 8'h90);
    host.wr(FET_CONTROL_ADDR, 8'h01);
    repeat (2) begin
      discharge_oc_detect = 1'h1;
      cyc(8);
      discharge_oc_detect = 1'h0;
      cyc(1);
    end
    cyc(4);
    chk("oc restart", 8'h00, {7'h00, discharge_oc_flag});
    oc_trip(BASE / DELAY_DIVIDE_FACTOR);
    chk("fet on", 8'h01, {7'h00, discharge_fet_enable});
    // A reset in mid-run must bring the settings and the FET back to zero.
    srst = 1'h1;
    cyc(2);
    chk("fet reset", 8'h00, {7'h00, discharge_fet_enable});
    srst = 1'h0;
    host.rd(DISCHARGE_CONFIG_ADDR, d);
    chk("config after reset", CONFIG_RESET, d);
    chk("divider reset", 8'h00, {7'h00, discharge_delay_divide});
    conclude();
  end
endmodule : testbench

bind discharge_protection_config discharge_protection_props #(
  .OC_BASE_TIMEOUT(OC_BASE_TIMEOUT)
) props (
  .clk(clk),
  .srst(srst),
  .reg_write_strobe(reg_write_strobe),
  .reg_read_strobe(reg_read_strobe),
  .reg_addr(reg_addr),
  .reg_write_data(reg_write_data),
  .reg_read_data(reg_read_data),
  .reg_read_valid(reg_read_valid),
  .discharge_oc_detect(discharge_oc_detect),
  .short_circuit_detect(short_circuit_detect),
  .discharge_oc_threshold_voltage(discharge_oc_threshold_voltage),
  .short_circuit_threshold_voltage(short_circuit_threshold_voltage),
  .discharge_fet_enable(discharge_fet_enable),
  .discharge_delay_divide(discharge_delay_divide),
  .discharge_oc_flag(discharge_oc_flag),
  .short_circuit_flag(short_circuit_flag),
  .temp_sensor_supply_out(temp_sensor_supply_out)
);
`default_nettype wire
